// ==== inc/crc_scan_pkg.sv ====
// Constants and types used by the CRC engine; its bit step does not use them.
// Assumes a byte-wide register port and a 16-bit program memory read port.
package crc_scan_pkg;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 4;
  localparam int WORD_W  = 16;
  localparam int FADDR_W = 16;
  localparam int CNT_W   = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MAIN_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_LENGTH_CFG   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DATA_LOW     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_DATA_HIGH    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_ACC_LOW      = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ACC_HIGH     = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_POLY_LOW     = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_POLY_HIGH    = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_SCAN_CONTROL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_SCAN_LO_L    = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_SCAN_LO_H    = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_SCAN_HI_L    = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_SCAN_HI_H    = 4'hC;
  localparam logic [ADDR_W-1:0] OFS_FLAGS        = 4'hD;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE   = 4'hE;

  // Main control bits
  localparam int BIT_CRC_EN    = 7;
  localparam int BIT_CRC_GO    = 6;
  localparam int BIT_BUSY      = 5;
  localparam int BIT_AUGMENT   = 4;
  localparam int BIT_SHIFT_DIR = 1;
  localparam int BIT_FULL      = 0;
  // Length config fields
  localparam int POS_PLEN = 4;
  localparam int POS_DLEN = 0;
  // Scanner control bits
  localparam int BIT_SCAN_EN   = 7;
  localparam int BIT_SCAN_GO   = 6;
  localparam int BIT_SCAN_BUSY = 5;
  localparam int POS_SCAN_INTERRUPT_MODE      = 3;
  localparam int POS_MODE      = 0;
  // Flag and enable bits
  localparam int BIT_CRC_DONE  = 0;
  localparam int BIT_SCAN_DONE = 1;

  // Reset values and the largest top bit index
  localparam logic [DATA_W-1:0]  RST_BYTE = 8'h00;
  localparam logic [WORD_W-1:0]  RST_WORD = 16'h0000;
  localparam logic [FADDR_W-1:0] RST_ADDR = 16'h0000;
  localparam logic [CNT_W-1:0]   RST_CNT  = 4'h0;
  localparam logic [CNT_W-1:0]   TOP_MAX  = 4'hF;

  typedef enum logic [1:0] {
    ENG_WAIT,
    ENG_SHIFT,
    ENG_AUGMENT
  } engine_state_t;

  typedef enum logic [1:0] {
    SCN_IDLE,
    SCN_WAIT,
    SCN_FETCH
  } scan_state_t;
endpackage

// ==== verilog/crc_bit_step.sv ====
// One shift of the CRC accumulator with polynomial feedback.
// Assumes the caller masks nothing; width comes from the top bit index.
`timescale 1ns/1ps
module crc_bit_step (
  input  wire logic [15:0] acc,
  input  wire logic [15:0] poly,
  input  wire logic [3:0]  top_idx,
  input  wire logic        data_bit,
  output logic      [15:0] acc_next
);
  logic [15:0] mask;
  logic        feedback;
  logic [15:0] shifted;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_mask
      assign mask[i] = (4'(i) <= top_idx);
    end
  endgenerate

  assign feedback = acc[top_idx] ^ data_bit;
  assign shifted  = {acc[14:0], 1'b0};
  assign acc_next = (shifted ^ (feedback ? poly : 16'h0000)) & mask;
endmodule

// ==== verilog/crc_scan_engine.sv ====
// CRC engine with program memory scanner behind a byte-wide register port.
// Assumes the memory answers a held read request with flash_valid on the same clock.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module crc_scan_engine (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [15:0] flash_addr,
  output logic             flash_rd,
  input  wire logic [15:0] flash_rdata,
  input  wire logic        flash_valid,
  input  wire logic        flash_unimpl,
  output logic             crc_irq,
  output logic             scan_irq
);
  logic                        rst_meta_reg;
  logic                        rst_sync_n;
  logic [7:0]                  main_ctrl_reg;
  logic [7:0]                  len_cfg_reg;
  logic [7:0]                  data_low_reg;
  logic [7:0]                  data_high_reg;
  logic                        pending_reg;
  logic [15:0]                 acc_reg;
  logic [15:0]                 poly_reg;
  logic                        scan_en_reg;
  logic                        scan_go_reg;
  logic                        scan_go_d_reg;
  logic [1:0]                  scan_scan_interrupt_mode_reg;
  logic [1:0]                  scan_mode_reg;
  logic [15:0]                 scan_lo_reg;
  logic [15:0]                 scan_hi_reg;
  logic [15:0]                 scan_addr_reg;
  logic                        crc_done_reg;
  logic                        scan_done_reg;
  logic                        crc_ie_reg;
  logic                        scan_ie_reg;
  logic                        busy_reg;
  logic [3:0]                  bit_cnt_reg;
  logic [15:0]                 shift_word_reg;
  crc_scan_pkg::engine_state_t eng_state_reg;
  crc_scan_pkg::scan_state_t   scan_state_reg;
  logic [7:0]                  rd_mux;
  logic [15:0]                 acc_next;
  logic                        data_bit;
  logic [3:0]                  top_idx;
  logic [3:0]                  dlen;
  logic                        crc_go;
  logic                        eng_load;
  logic                        eng_finish;
  logic                        scan_active;
  logic                        scan_load;
  logic                        scan_stop;
  logic                        wr_scan;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  assign wr_scan     = reg_wr && (reg_addr == crc_scan_pkg::OFS_SCAN_CONTROL);
  assign crc_go      = main_ctrl_reg[crc_scan_pkg::BIT_CRC_EN] &&
                       main_ctrl_reg[crc_scan_pkg::BIT_CRC_GO];
  assign dlen        = len_cfg_reg[crc_scan_pkg::POS_DLEN +: 4];
  // Width above 16 bits is clipped to the accumulator size
  assign top_idx     = (len_cfg_reg[crc_scan_pkg::POS_PLEN +: 4] == crc_scan_pkg::TOP_MAX) ?
                       crc_scan_pkg::TOP_MAX : len_cfg_reg[crc_scan_pkg::POS_PLEN +: 4] + 4'h1;
  assign scan_active = scan_en_reg && scan_go_reg;
  assign eng_load    = (eng_state_reg == crc_scan_pkg::ENG_WAIT) && crc_go && pending_reg;
  // Waiting on the scanner between words must not end the calculation
  assign eng_finish  = (eng_state_reg == crc_scan_pkg::ENG_WAIT) && busy_reg &&
                       !eng_load && !scan_active;
  assign scan_load   = (scan_state_reg == crc_scan_pkg::SCN_FETCH) && flash_valid &&
                       !flash_unimpl && scan_active;
  assign scan_stop   = (scan_state_reg == crc_scan_pkg::SCN_FETCH) && flash_valid &&
                       scan_active && (flash_unimpl || scan_addr_reg == scan_hi_reg);

  always_comb begin
    if (eng_state_reg == crc_scan_pkg::ENG_AUGMENT) begin
      data_bit = 1'b0;
    end else if (main_ctrl_reg[crc_scan_pkg::BIT_SHIFT_DIR]) begin
      data_bit = shift_word_reg[dlen];
    end else begin
      data_bit = shift_word_reg[0];
    end
  end

  crc_bit_step u_step (
    .acc      (acc_reg),
    .poly     (poly_reg),
    .top_idx  (top_idx),
    .data_bit (data_bit),
    .acc_next (acc_next)
  );

  // Control and configuration registers
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      main_ctrl_reg <= crc_scan_pkg::RST_BYTE;
      len_cfg_reg   <= crc_scan_pkg::RST_BYTE;
      poly_reg      <= crc_scan_pkg::RST_WORD;
      scan_lo_reg   <= crc_scan_pkg::RST_ADDR;
      scan_hi_reg   <= crc_scan_pkg::RST_ADDR;
      scan_scan_interrupt_mode_reg <= 2'h0;
      scan_mode_reg <= 2'h0;
      scan_en_reg   <= 1'b0;
      crc_ie_reg    <= 1'b0;
      scan_ie_reg   <= 1'b0;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        crc_scan_pkg::OFS_MAIN_CONTROL: main_ctrl_reg <= reg_wdata;
        crc_scan_pkg::OFS_LENGTH_CFG:   len_cfg_reg <= reg_wdata;
        crc_scan_pkg::OFS_POLY_LOW:     poly_reg[7:0] <= reg_wdata;
        crc_scan_pkg::OFS_POLY_HIGH:    poly_reg[15:8] <= reg_wdata;
        crc_scan_pkg::OFS_SCAN_LO_L:    scan_lo_reg[7:0] <= reg_wdata;
        crc_scan_pkg::OFS_SCAN_LO_H:    scan_lo_reg[15:8] <= reg_wdata;
        crc_scan_pkg::OFS_SCAN_HI_L:    scan_hi_reg[7:0] <= reg_wdata;
        crc_scan_pkg::OFS_SCAN_HI_H:    scan_hi_reg[15:8] <= reg_wdata;
        crc_scan_pkg::OFS_SCAN_CONTROL: begin
          scan_en_reg   <= reg_wdata[crc_scan_pkg::BIT_SCAN_EN];
          scan_scan_interrupt_mode_reg <= reg_wdata[crc_scan_pkg::POS_SCAN_INTERRUPT_MODE +: 2];
          scan_mode_reg <= reg_wdata[crc_scan_pkg::POS_MODE +: 2];
        end
        crc_scan_pkg::OFS_INT_ENABLE: begin
          crc_ie_reg  <= reg_wdata[crc_scan_pkg::BIT_CRC_DONE];
          scan_ie_reg <= reg_wdata[crc_scan_pkg::BIT_SCAN_DONE];
        end
        default: begin
        end
      endcase
    end
  end

  // Scan-go: software sets or aborts, the scanner clears it at the end
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scan_go_reg   <= 1'b0;
      scan_go_d_reg <= 1'b0;
    end else if (ce) begin
      scan_go_d_reg <= scan_go_reg;
      if (scan_stop) begin
        scan_go_reg <= 1'b0;
      end else if (wr_scan) begin
        scan_go_reg <= reg_wdata[crc_scan_pkg::BIT_SCAN_GO];
      end
    end
  end

  // Data registers are shared by software and the scanner
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_low_reg  <= crc_scan_pkg::RST_BYTE;
      data_high_reg <= crc_scan_pkg::RST_BYTE;
      pending_reg   <= 1'b0;
    end else if (ce) begin
      if (scan_load) begin
        data_low_reg  <= flash_rdata[7:0];
        data_high_reg <= flash_rdata[15:8];
        pending_reg   <= 1'b1;
      end else if (reg_wr && reg_addr == crc_scan_pkg::OFS_DATA_LOW) begin
        data_low_reg <= reg_wdata;
        pending_reg  <= 1'b1;
      end else begin
        if (reg_wr && reg_addr == crc_scan_pkg::OFS_DATA_HIGH) begin
          data_high_reg <= reg_wdata;
        end
        if (eng_load) begin
          pending_reg <= 1'b0;
        end
      end
    end
  end

  // Shift engine
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      eng_state_reg  <= crc_scan_pkg::ENG_WAIT;
      busy_reg       <= 1'b0;
      bit_cnt_reg    <= crc_scan_pkg::RST_CNT;
      shift_word_reg <= crc_scan_pkg::RST_WORD;
      acc_reg        <= crc_scan_pkg::RST_WORD;
    end else if (ce) begin
      unique case (eng_state_reg)
        crc_scan_pkg::ENG_WAIT: begin
          if (eng_load) begin
            shift_word_reg <= {data_high_reg, data_low_reg};
            bit_cnt_reg    <= crc_scan_pkg::RST_CNT;
            busy_reg       <= 1'b1;
            eng_state_reg  <= crc_scan_pkg::ENG_SHIFT;
          end else if (eng_finish && main_ctrl_reg[crc_scan_pkg::BIT_AUGMENT]) begin
            bit_cnt_reg   <= crc_scan_pkg::RST_CNT;
            eng_state_reg <= crc_scan_pkg::ENG_AUGMENT;
          end else if (eng_finish) begin
            busy_reg <= 1'b0;
          end
        end
        crc_scan_pkg::ENG_SHIFT: begin
          acc_reg     <= acc_next;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (main_ctrl_reg[crc_scan_pkg::BIT_SHIFT_DIR]) begin
            shift_word_reg <= {shift_word_reg[14:0], 1'b0};
          end else begin
            shift_word_reg <= {1'b0, shift_word_reg[15:1]};
          end
          if (bit_cnt_reg == dlen) begin
            eng_state_reg <= crc_scan_pkg::ENG_WAIT;
          end
        end
        crc_scan_pkg::ENG_AUGMENT: begin
          acc_reg     <= acc_next;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == top_idx) begin
            busy_reg      <= 1'b0;
            eng_state_reg <= crc_scan_pkg::ENG_WAIT;
          end
        end
        default: begin
          eng_state_reg <= crc_scan_pkg::ENG_WAIT;
        end
      endcase
      if (!busy_reg && reg_wr && reg_addr == crc_scan_pkg::OFS_ACC_LOW) begin
        acc_reg[7:0] <= reg_wdata;
      end else if (!busy_reg && reg_wr && reg_addr == crc_scan_pkg::OFS_ACC_HIGH) begin
        acc_reg[15:8] <= reg_wdata;
      end
    end
  end

  // Memory scanner; every mode runs as back-to-back fetches paced by the engine
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scan_state_reg <= crc_scan_pkg::SCN_IDLE;
      scan_addr_reg  <= crc_scan_pkg::RST_ADDR;
      flash_addr     <= crc_scan_pkg::RST_ADDR;
      flash_rd       <= 1'b0;
    end else if (ce) begin
      if (!scan_active) begin
        scan_state_reg <= crc_scan_pkg::SCN_IDLE;
        flash_rd       <= 1'b0;
      end else begin
        unique case (scan_state_reg)
          crc_scan_pkg::SCN_IDLE: begin
            scan_addr_reg  <= scan_lo_reg;
            scan_state_reg <= crc_scan_pkg::SCN_WAIT;
          end
          crc_scan_pkg::SCN_WAIT: begin
            if (crc_go && !pending_reg) begin
              flash_addr     <= scan_addr_reg;
              flash_rd       <= 1'b1;
              scan_state_reg <= crc_scan_pkg::SCN_FETCH;
            end
          end
          crc_scan_pkg::SCN_FETCH: begin
            if (flash_valid) begin
              flash_rd      <= 1'b0;
              scan_addr_reg <= scan_addr_reg + 16'h0001;
              if (scan_stop) begin
                scan_state_reg <= crc_scan_pkg::SCN_IDLE;
              end else begin
                scan_state_reg <= crc_scan_pkg::SCN_WAIT;
              end
            end
          end
          default: begin
            scan_state_reg <= crc_scan_pkg::SCN_IDLE;
          end
        endcase
      end
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crc_done_reg  <= 1'b0;
      scan_done_reg <= 1'b0;
      crc_irq       <= 1'b0;
      scan_irq      <= 1'b0;
    end else if (ce) begin
      if ((eng_finish && !main_ctrl_reg[crc_scan_pkg::BIT_AUGMENT]) ||
          (eng_state_reg == crc_scan_pkg::ENG_AUGMENT && bit_cnt_reg == top_idx)) begin
        crc_done_reg <= 1'b1;
      end else if (reg_wr && reg_addr == crc_scan_pkg::OFS_FLAGS &&
                   reg_wdata[crc_scan_pkg::BIT_CRC_DONE]) begin
        crc_done_reg <= 1'b0;
      end
      if (scan_go_d_reg && !scan_go_reg) begin
        scan_done_reg <= 1'b1;
      end else if (reg_wr && reg_addr == crc_scan_pkg::OFS_FLAGS &&
                   reg_wdata[crc_scan_pkg::BIT_SCAN_DONE]) begin
        scan_done_reg <= 1'b0;
      end
      crc_irq  <= crc_done_reg && crc_ie_reg;
      scan_irq <= scan_done_reg && scan_ie_reg;
    end
  end

  always_comb begin
    rd_mux = crc_scan_pkg::RST_BYTE;
    unique case (reg_addr)
      crc_scan_pkg::OFS_MAIN_CONTROL: begin
        rd_mux = main_ctrl_reg;
        rd_mux[crc_scan_pkg::BIT_BUSY] = busy_reg;
        rd_mux[crc_scan_pkg::BIT_FULL] = pending_reg;
      end
      crc_scan_pkg::OFS_LENGTH_CFG:   rd_mux = len_cfg_reg;
      crc_scan_pkg::OFS_DATA_LOW:     rd_mux = data_low_reg;
      crc_scan_pkg::OFS_DATA_HIGH:    rd_mux = data_high_reg;
      crc_scan_pkg::OFS_ACC_LOW:      rd_mux = acc_reg[7:0];
      crc_scan_pkg::OFS_ACC_HIGH:     rd_mux = acc_reg[15:8];
      crc_scan_pkg::OFS_POLY_LOW:     rd_mux = poly_reg[7:0];
      crc_scan_pkg::OFS_POLY_HIGH:    rd_mux = poly_reg[15:8];
      crc_scan_pkg::OFS_SCAN_CONTROL: begin
        rd_mux[crc_scan_pkg::BIT_SCAN_EN]      = scan_en_reg;
        rd_mux[crc_scan_pkg::BIT_SCAN_GO]      = scan_go_reg;
        rd_mux[crc_scan_pkg::BIT_SCAN_BUSY]    = scan_state_reg != crc_scan_pkg::SCN_IDLE;
        rd_mux[crc_scan_pkg::POS_SCAN_INTERRUPT_MODE +: 2]    = scan_scan_interrupt_mode_reg;
        rd_mux[crc_scan_pkg::POS_MODE +: 2]    = scan_mode_reg;
      end
      crc_scan_pkg::OFS_SCAN_LO_L:    rd_mux = scan_lo_reg[7:0];
      crc_scan_pkg::OFS_SCAN_LO_H:    rd_mux = scan_lo_reg[15:8];
      crc_scan_pkg::OFS_SCAN_HI_L:    rd_mux = scan_hi_reg[7:0];
      crc_scan_pkg::OFS_SCAN_HI_H:    rd_mux = scan_hi_reg[15:8];
      crc_scan_pkg::OFS_FLAGS: begin
        rd_mux[crc_scan_pkg::BIT_CRC_DONE]  = crc_done_reg;
        rd_mux[crc_scan_pkg::BIT_SCAN_DONE] = scan_done_reg;
      end
      crc_scan_pkg::OFS_INT_ENABLE: begin
        rd_mux[crc_scan_pkg::BIT_CRC_DONE]  = crc_ie_reg;
        rd_mux[crc_scan_pkg::BIT_SCAN_DONE] = scan_ie_reg;
      end
      default: rd_mux = crc_scan_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= crc_scan_pkg::RST_BYTE;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : crc_scan_pkg::RST_BYTE;
    end
  end

  AST_LOW_WRITE_QUEUES: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ce && reg_wr && reg_addr == crc_scan_pkg::OFS_DATA_LOW |=> pending_reg)
    else $error("low byte write did not queue a word");
  AST_GO_STARTS_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ce && eng_load |=> eng_state_reg == crc_scan_pkg::ENG_SHIFT && busy_reg)
    else $error("queued word not taken with go set");
  AST_SHIFT_COUNT: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    eng_state_reg == crc_scan_pkg::ENG_SHIFT |-> bit_cnt_reg <= dlen)
    else $error("shift count ran past data length");
  AST_DONE_CLEARS_BUSY: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $rose(crc_done_reg) |-> !busy_reg && $past(busy_reg))
    else $error("done flag without busy falling");
  AST_SHIFT_BUSY: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    eng_state_reg != crc_scan_pkg::ENG_WAIT |-> busy_reg)
    else $error("busy low while shifting");
  AST_STOP_CLEARS_GO: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ce && scan_stop |=> !scan_go_reg && scan_state_reg == crc_scan_pkg::SCN_IDLE)
    else $error("scanner kept running after its end");
  AST_FALL_SETS_FLAG: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ce && scan_go_d_reg && !scan_go_reg |=> scan_done_reg)
    else $error("scan-go fall did not set the done flag");
  AST_FETCH_WHEN_READY: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $rose(flash_rd) |-> $past(crc_go) && !$past(pending_reg))
    else $error("fetch before engine was ready");
  AST_DISABLE_RESETS: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ce && !scan_en_reg |=> scan_state_reg == crc_scan_pkg::SCN_IDLE && !flash_rd)
    else $error("scanner state survived disable");
endmodule

// ==== testbench/flash_model.sv ====
// Program memory model: answers held reads, prompt and slow in turn, starting prompt.
// Assumes one read at a time; words above LAST_IMPL are unimplemented.
`timescale 1ns/1ps
module flash_model #(parameter logic [15:0] LAST_IMPL = 16'h0013) (
  input  wire logic        core_clk,
  input  wire logic [15:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [15:0] flash_rdata = 16'h0000,
  output logic             flash_valid = 1'b0,
  output logic             flash_unimpl = 1'b0
);
  logic [1:0] wait_cnt = 2'h0;
  logic       slow     = 1'b0;
  always @(posedge core_clk) begin
    flash_valid <= 1'b0;
    flash_unimpl <= 1'b0;
    // Idle data toggles so a stale word never looks valid
    flash_rdata <= ~flash_rdata;
    if (flash_rd && !flash_valid) begin
      if (wait_cnt == 2'h0) begin
        flash_valid <= 1'b1;
        flash_rdata <= flash_addr ^ 16'hA5C3;
        flash_unimpl <= (flash_addr > LAST_IMPL);
        wait_cnt <= slow ? 2'h0 : 2'h2;
        slow <= ~slow;
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

// ==== testbench/crc_scan_engine_bench.sv ====
// Bench: manual CRC words in four modes, two scans, an abort, status and freeze checks.
// Assumes flash_model as the memory and the engine's byte register map.
`timescale 1ns/1ps
module crc_scan_engine_bench;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        ce        = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, rd_val;
  logic [15:0] flash_addr, flash_rdata, exp_acc, word;
  logic        flash_rd, flash_valid, flash_unimpl, crc_irq, scan_irq;
  int          miscompares = 0;
  int          total_checks = 0;
  int          top;
  crc_scan_engine uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_valid(flash_valid), .flash_unimpl(flash_unimpl), .crc_irq(crc_irq),
    .scan_irq(scan_irq));
  flash_model mem (.core_clk(core_clk), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .flash_valid(flash_valid), .flash_unimpl(flash_unimpl));
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Bounded wait for a status bit to drop
  task automatic poll(input logic [3:0] a, input int b);
    for (int n = 0; n < 400 && rd_val[b] !== 1'b0; n++) rd(a);
    chk(rd_val[b], 1'b0);
  endtask
  function automatic logic [15:0] step(input logic [15:0] a, input logic b, input logic [15:0] p);
    return ((a << 1) ^ ((a[top] ^ b) ? p : 16'h0000)) & (16'hFFFF >> (15 - top));
  endfunction
  task automatic scan(input logic [7:0] hi, input int n);
    wr(4'hD, 8'h03);
    wr(4'h1, 8'hEF);
    wr(4'h6, 8'h21);
    wr(4'h7, 8'h10);
    wr(4'h4, 8'hFF);
    wr(4'h5, 8'hFF);
    wr(4'h9, 8'h10);
    wr(4'hB, hi);
    wr(4'h0, 8'hC2);
    wr(4'hE, 8'h03);
    wr(4'h8, 8'hC0);
    top = 15;
    exp_acc = 16'hFFFF;
    for (int w = 0; w < n; w++) begin
      word = (16'h0010 + w[15:0]) ^ 16'hA5C3;
      for (int i = 0; i < 16; i++) exp_acc = step(exp_acc, word[15 - i], 16'h1021);
    end
    rd_val = 8'hFF;
    poll(4'h8, 6);
    rd_val = 8'hFF;
    poll(4'h0, 5);
    rd(4'hD);
    chk(rd_val[1:0], 2'b11);
    chk({crc_irq, scan_irq}, 2'b11);
    rd(4'h4);
    chk(rd_val, exp_acc[7:0]);
    rd(4'h5);
    chk(rd_val, exp_acc[15:8]);
    $display("scan test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int c = 0; c < 4; c++) begin
      top = 7;
      wr(4'h1, 8'h67);
      wr(4'h6, 8'h07);
      wr(4'h4, 8'hA5 + c[7:0]);
      wr(4'h0, {3'b110, c[1], 2'b00, c[0], 1'b0});
      wr(4'h3, 8'h00);
      wr(4'h2, 8'h3C ^ c[7:0]);
      exp_acc = 16'h00A5 + c[15:0];
      word = 16'h003C ^ c[15:0];
      for (int i = 0; i < 8; i++) exp_acc = step(exp_acc, word[c[0] ? 7 - i : i], 16'h0007);
      if (c[1]) for (int i = 0; i <= top; i++) exp_acc = step(exp_acc, 1'b0, 16'h0007);
      rd_val = 8'hFF;
      poll(4'h0, 5);
      rd(4'h4);
      chk(rd_val, exp_acc[7:0]);
      $display("manual test %0d done", c);
    end
    scan(8'h12, 3);
    scan(8'h18, 4);
    wr(4'hD, 8'h03);
    wr(4'h8, 8'hC0);
    wr(4'h8, 8'h80);
    rd(4'hD);
    chk(rd_val[1], 1'b1);
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk(rd_val, 8'h00);
    wr(4'h8, 8'h9B);
    rd(4'h8);
    chk(rd_val, 8'h9B);
    // Go left low: the word must wait and show as full
    wr(4'h0, 8'h80);
    wr(4'h2, 8'h5A);
    rd(4'h0);
    chk(rd_val, 8'h81);
    @(posedge core_clk);
    #1 chk(reg_rdata, 8'h00);
    ce <= 1'b0;
    wr(4'h9, 8'h55);
    ce <= 1'b1;
    rd(4'h9);
    chk(rd_val, 8'h10);
    $display("abort, unmapped and status test done");
    results();
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule
